/* core/sync_slave_pkg.sv */
/*
  shared constants for the synchronous slave serial port and its master.
  assumes: both ends share sys_clk; the shift clock is sampled, not used as a clock.
*/
package sync_slave_pkg;
  // =====================================================
  // register map of the device-side firmware port
  localparam logic [3:0] ADDR_TX_CTRL   = 4'h0; // transmit_status_control
  localparam logic [3:0] ADDR_RX_CTRL   = 4'h1; // receive_status_control
  localparam logic [3:0] ADDR_TX_HOLD   = 4'h2; // transmit_holding_register
  localparam logic [3:0] ADDR_RX_BUF    = 4'h3; // receive_buffer
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4; // sticky event status
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5; // interrupt enables
  // =====================================================
  // transmit control field positions
  localparam int TXC_NINTH_BIT  = 0; // transmit_ninth_bit
  localparam int TXC_NINE_SEL   = 6; // nine_bit_transmit_select
  localparam int TXC_ENABLE     = 5; // transmit_enable
  localparam int TXC_SYNC       = 4; // synchronous mode
  localparam int TXC_CLK_SRC    = 7; // clock_source_select
  // receive control field positions
  localparam int RXC_PORT_EN    = 7; // port_enable
  localparam int RXC_NINE_SEL   = 6; // nine_bit_receive_select
  localparam int RXC_SINGLE     = 5; // single_receive_enable
  localparam int RXC_CONT       = 4; // continuous_receive_enable
  localparam int RXC_FRAME_ERR  = 2; // framing_error_flag
  localparam int RXC_OVERRUN    = 1; // overrun flag
  localparam int RXC_NINTH      = 0; // received ninth bit
  // interrupt bit positions
  localparam int IRQ_TX_EMPTY   = 0; // transmit_empty_flag
  localparam int IRQ_RX_FULL    = 1; // receive_full_flag
  // =====================================================
  // reset values
  localparam logic [7:0] TX_CTRL_RST    = 8'h00;
  localparam logic [7:0] RX_CTRL_RST    = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST   = 2'h0;
  // word lengths
  localparam int WORD_BITS_8    = 8;
  localparam int WORD_BITS_9    = 9;
  // master shift clock: half period in sys_clk cycles (160 ns period at 8 ns)
  localparam int SCK_HALF_CYC   = 10;
endpackage

/* core/sync_link_if.sv */
/*
  link between the external shift clock master and the slave serial port.
  assumes: single data line is two-way; the bench resolves the wire level.
*/
`timescale 1ns/1ps
interface sync_link_if;
  logic sck;      // shift clock, driven by master
  logic dat_mst_o; // data driven by master
  logic dat_mst_oe; // master drives data
  logic dat_slv_o; // data driven by slave
  logic dat_slv_oe; // slave drives data
  logic dat_i;    // resolved data line level
  modport master (output sck, output dat_mst_o, output dat_mst_oe, input dat_i);
  modport slave  (input sck, output dat_slv_o, output dat_slv_oe, input dat_i);
endinterface

/* core/sync_slave_port.sv */
/*
  device end: synchronous slave serial port with firmware register port.
  assumes: shift clock and data arrive unsynchronised; firmware uses the
  plain strobe port; sleep is a level input that never stops this logic.
*/
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module sync_slave_port
  import sync_slave_pkg::*;
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       sys_rst,   // async reset, high
  sync_link_if.slave      link,      // serial link
  input  wire logic       sleep,     // core sleep level, informational
  input  wire logic [3:0] reg_addr,  // register address
  input  wire logic [7:0] reg_wdata, // write data
  input  wire logic       reg_wr,    // write strobe
  input  wire logic       reg_rd,    // read strobe
  output logic      [7:0] reg_rdata, // read data, cycle after read
  output logic            irq,       // level interrupt
  output logic            wake       // wake request to sleeping core
);
  // =====================================================
  // registers
  logic [7:0] tx_ctrl_r;       // transmit_status_control
  logic [7:0] rx_ctrl_r;       // receive_status_control (control bits)
  logic [8:0] tx_hold_r;       // transmit_holding_register
  logic       tx_hold_full_r;  // holding register occupied
  logic [8:0] tx_shift_r;      // transmit_shift_register
  logic [3:0] tx_cnt_r;        // bits left in shifter
  logic [8:0] rx_shift_r;      // receive_shift_register
  logic [3:0] rx_cnt_r;        // bits received
  logic [7:0] rx_buf_r;        // receive_buffer
  logic       rx_ninth_r;      // ninth bit of buffered word
  logic       rx_full_r;       // buffer holds unread word
  logic       framing_error_flag_r;          // framing_error_flag
  logic       oerr_r;          // overrun flag
  logic [1:0] irq_stat_r;      // sticky events
  logic [1:0] irq_mask_r;      // interrupt enables
  logic [2:0] sck_sync_r;      // shift clock synchroniser + history
  logic [1:0] dat_sync_r;      // data synchroniser
  logic       sck_rise;        // shift clock rising edge
  logic       sck_fall;        // shift clock falling edge
  logic       slave_mode;      // configured as slave
  logic       port_on;         // port enabled
  logic       rx_on;           // reception enabled
  logic       tx_done;         // shifter emptied this cycle
  logic       rx_done;         // word completed this cycle
  logic       buf_rd;          // firmware reads the receive buffer
  logic [3:0] tx_len;          // transmit word length
  logic [3:0] rx_len;          // receive word length

  // =====================================================
  // decode
  assign slave_mode = ~tx_ctrl_r[TXC_CLK_SRC] & tx_ctrl_r[TXC_SYNC];
  assign port_on    = rx_ctrl_r[RXC_PORT_EN];
  assign rx_on      = port_on & slave_mode & rx_ctrl_r[RXC_CONT];
  assign tx_len     = tx_ctrl_r[TXC_NINE_SEL] ? 4'(WORD_BITS_9) : 4'(WORD_BITS_8);
  assign rx_len     = rx_ctrl_r[RXC_NINE_SEL] ? 4'(WORD_BITS_9) : 4'(WORD_BITS_8);
  assign buf_rd     = reg_rd && (reg_addr == ADDR_RX_BUF);
  assign sck_rise   = sck_sync_r[1] & ~sck_sync_r[2];
  assign sck_fall   = ~sck_sync_r[1] & sck_sync_r[2];
  // sleep gates only wake: the external clock keeps us going

  // =====================================================
  // synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
    end else begin
      sck_sync_r <= {sck_sync_r[1:0], link.sck};
      dat_sync_r <= {dat_sync_r[0], link.dat_i};
    end
  end

  // =====================================================
  // control register writes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ctrl_r  <= TX_CTRL_RST;
      rx_ctrl_r  <= RX_CTRL_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_TX_CTRL) begin
        tx_ctrl_r <= reg_wdata;
      end else if (reg_addr == ADDR_RX_CTRL) begin
        rx_ctrl_r <= {reg_wdata[7:4], 4'h0}; // status bits are read-only
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        irq_mask_r <= reg_wdata[1:0];
      end
    end
  end

  // =====================================================
  // transmit: holding register feeds shifter
  assign tx_done = (tx_cnt_r == 4'h1) && sck_fall;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hold_r      <= 9'h000;
      tx_hold_full_r <= 1'b0;
      tx_shift_r     <= 9'h000;
      tx_cnt_r       <= 4'h0;
    end else begin
      // firmware load of holding register
      if (reg_wr && reg_addr == ADDR_TX_HOLD) begin
        tx_hold_r      <= {tx_ctrl_r[TXC_NINTH_BIT], reg_wdata};
        tx_hold_full_r <= 1'b1;
      end
      if (!port_on || !tx_ctrl_r[TXC_ENABLE] || !slave_mode) begin
        tx_cnt_r <= 4'h0; // idle until enabled
      end else if ((tx_cnt_r == 4'h0 || tx_done) && tx_hold_full_r) begin
        // move held word into shifter
        tx_shift_r <= tx_hold_r;
        tx_cnt_r   <= tx_len;
        if (!(reg_wr && reg_addr == ADDR_TX_HOLD)) begin
          tx_hold_full_r <= 1'b0;
        end
      end else if (sck_fall && tx_cnt_r != 4'h0) begin
        tx_shift_r <= {1'b0, tx_shift_r[8:1]}; // lsb first
        tx_cnt_r   <= tx_cnt_r - 4'h1;
      end
    end
  end

  // drive data only while a word is in the shifter
  assign link.dat_slv_o  = tx_shift_r[0];
  assign link.dat_slv_oe = (tx_cnt_r != 4'h0);

  // =====================================================
  // receive: shifter feeds buffer
  assign rx_done = rx_on && sck_rise && (rx_cnt_r == rx_len - 4'h1);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift_r <= 9'h000;
      rx_cnt_r   <= 4'h0;
    end else if (!rx_on) begin
      rx_shift_r <= 9'h000; // abort to idle
      rx_cnt_r   <= 4'h0;
    end else if (sck_rise) begin
      // sample lsb first into position
      rx_shift_r[rx_cnt_r] <= dat_sync_r[1];
      rx_cnt_r             <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  // buffer, ninth bit and error flags
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_buf_r   <= 8'h00;
      rx_ninth_r <= 1'b0;
      rx_full_r  <= 1'b0;
      framing_error_flag_r     <= 1'b0;
      oerr_r     <= 1'b0;
    end else begin
      if (buf_rd) begin
        rx_full_r <= 1'b0;
        framing_error_flag_r    <= 1'b0; // no stop bit in sync mode
      end
      if (rx_done) begin
        if (rx_full_r && !buf_rd) begin
          oerr_r <= 1'b1; // incoming word lost, unread word kept in buffer
        end else begin
          // in 8-bit words the last bit is still on the line this cycle
          rx_buf_r   <= (rx_len == 4'(WORD_BITS_9)) ? rx_shift_r[7:0] :
                        {dat_sync_r[1], rx_shift_r[6:0]};
          rx_ninth_r <= rx_ctrl_r[RXC_NINE_SEL] ? dat_sync_r[1] : 1'b0;
          rx_full_r  <= 1'b1;
        end
      end else if (!rx_ctrl_r[RXC_CONT]) begin
        oerr_r <= 1'b0;
      end
      if (!port_on) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // sticky events; set wins over write-one clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && reg_addr == ADDR_IRQ_STAT && reg_wdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
      if (tx_done && tx_hold_full_r) begin
        irq_stat_r[IRQ_TX_EMPTY] <= 1'b1; // second word taken
      end else if (tx_done && !tx_hold_full_r) begin
        irq_stat_r[IRQ_TX_EMPTY] <= 1'b1;
      end
      if (rx_done && !(rx_full_r && !buf_rd)) begin
        irq_stat_r[IRQ_RX_FULL] <= 1'b1;
      end
    end
  end

  // interrupt and wake; vectoring is the core's
  assign irq  = |(irq_stat_r & irq_mask_r);
  assign wake = irq & sleep;

  // =====================================================
  // read port, data one cycle later; firmware reads status first
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_TX_CTRL) begin
        reg_rdata <= {tx_ctrl_r[7:2], ~tx_hold_full_r, tx_ctrl_r[0]};
      end else if (reg_addr == ADDR_RX_CTRL) begin
        reg_rdata <= {rx_ctrl_r[7:4], 1'b0, framing_error_flag_r, oerr_r, rx_ninth_r};
      end else if (reg_addr == ADDR_RX_BUF) begin
        reg_rdata <= rx_buf_r;
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        reg_rdata <= {6'h00, irq_stat_r};
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        reg_rdata <= {6'h00, irq_mask_r};
      end else begin
        reg_rdata <= 8'h00; // unmapped
      end
    end
  end
endmodule

/* core/sync_clock_master.sv */
/*
  far end: synchronous master that makes the shift clock and moves one word
  per request, sent to the slave when drive is set, else read from it.
  assumes: the slave samples on rising and shifts on falling edges.
*/
`timescale 1ns/1ps
module sync_clock_master
  import sync_slave_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC // half shift clock period in cycles
)(
  input  wire logic       sys_clk,  // system clock
  input  wire logic       sys_rst,  // async reset, high
  sync_link_if.master     link,     // serial link
  input  wire logic       start,    // one-cycle request
  input  wire logic       drive,    // master drives data (slave receives)
  input  wire logic [3:0] nbits,    // bits in the word, 8 or 9
  input  wire logic [8:0] tx_word,  // word to send, lsb first
  output logic            busy,     // word in progress
  output logic            done,     // one-cycle end pulse
  output logic      [8:0] rx_word   // word sampled from slave
);
  // =====================================================
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} mst_state_t;
  mst_state_t state_r;            // master state
  logic [7:0] div_r;              // clock divider
  logic [3:0] bit_r;              // bit index
  logic [8:0] sh_r;               // outgoing word
  logic [3:0] len_r;              // word length
  logic       drv_r;              // drive flag
  logic [1:0] din_sync_r;         // data synchroniser

  assign busy            = (state_r != ST_IDLE);
  assign link.sck        = (state_r == ST_HIGH);
  assign link.dat_mst_o  = sh_r[0];
  assign link.dat_mst_oe = drv_r & busy;

  // =====================================================
  // data synchroniser
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      din_sync_r <= 2'h0;
    end else begin
      din_sync_r <= {din_sync_r[0], link.dat_i};
    end
  end

  // =====================================================
  // clock generation and shifting, lsb first
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      div_r   <= 8'h00;
      bit_r   <= 4'h0;
      sh_r    <= 9'h000;
      len_r   <= 4'h0;
      drv_r   <= 1'b0;
      rx_word <= 9'h000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            sh_r    <= tx_word;
            len_r   <= nbits;
            drv_r   <= drive;
            bit_r   <= 4'h0;
            div_r   <= 8'h00;
            rx_word <= 9'h000;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (div_r == 8'(HALF - 1)) begin
            div_r   <= 8'h00;
            state_r <= ST_HIGH;
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
        ST_HIGH: begin
          if (div_r == 8'(HALF - 1)) begin
            // sample late in high phase, then fall
            rx_word[bit_r] <= din_sync_r[1];
            sh_r           <= {1'b0, sh_r[8:1]};
            div_r          <= 8'h00;
            if (bit_r == len_r - 4'h1) begin
              state_r <= ST_IDLE;
              done    <= 1'b1;
            end else begin
              bit_r   <= bit_r + 4'h1;
              state_r <= ST_LOW;
            end
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* tb/sync_link_chk.sv */
/*
  checker on the shift link wires between clock master and slave port.
  assumes: all link signals are sampled on sys_clk; sys_rst is async high.
*/
`timescale 1ns/1ps
module sync_link_chk
  import sync_slave_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYC // half shift clock period in cycles
)(
  input wire logic sys_clk,    // system clock
  input wire logic sys_rst,    // async reset, high
  input wire logic sck,        // shift clock
  input wire logic dat_mst_o,  // master data
  input wire logic dat_mst_oe, // master drives
  input wire logic dat_slv_o,  // slave data
  input wire logic dat_slv_oe, // slave drives
  input wire logic dat_i       // resolved line
);
  // =====================================================
  // phase and edge counters
  localparam int GAP = 2 * HALF + 1; // low this long ends a frame
  logic [7:0] hi_cnt; // cycles sck seen high
  logic [7:0] lo_cnt; // cycles sck seen low, saturating
  logic [3:0] nrise;  // rising edges in this frame
  // high phase length
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) hi_cnt <= 8'h00;
    else hi_cnt <= sck ? hi_cnt + 8'h01 : 8'h00;
  end
  // low phase length
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) lo_cnt <= 8'h00;
    else if (sck) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  // edges per frame, cleared by a long low gap
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) nrise <= 4'h0;
    else if (sck && hi_cnt == 8'h00) nrise <= nrise + 4'h1;
    else if (lo_cnt == 8'(GAP)) nrise <= 4'h0;
  end
  // =====================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rise; !sck ##1 sck; endsequence
  sequence s_fall; sck ##1 !sck; endsequence
  chk_high_len: assert property (s_fall |-> hi_cnt == 8'(HALF))
    else $error("shift clock high phase has wrong length");
  chk_low_len: assert property (s_rise |->
    (nrise == 4'h0 ? lo_cnt >= 8'(HALF) : lo_cnt == 8'(HALF)))
    else $error("shift clock low phase has wrong length");
  chk_bit_count: assert property ((lo_cnt == 8'(GAP) && nrise != 4'h0) |->
    (nrise == 4'h8 || nrise == 4'h9))
    else $error("frame has wrong number of clocks");
  chk_no_fight: assert property (!(dat_mst_oe && dat_slv_oe))
    else $error("both ends drive the data line");
  chk_slv_stable: assert property ((sck && $past(sck) && dat_slv_oe &&
    $past(dat_slv_oe)) |-> $stable(dat_slv_o))
    else $error("slave data moved while clock high");
  chk_mst_stable: assert property ((sck && $past(sck) && dat_mst_oe &&
    $past(dat_mst_oe)) |-> $stable(dat_mst_o))
    else $error("master data moved while clock high");
  chk_slv_release: assert property ($fell(dat_slv_oe) |-> !sck)
    else $error("slave released line while clock high");
  chk_word_whole: assert property ((dat_slv_oe && nrise != 4'h0 &&
    nrise < 4'h8) |=> dat_slv_oe)
    else $error("slave dropped line inside a word");
endmodule

/* tb/tb_usart_sync_slave_port.sv */
/*
  self-checking bench: slave port and clock master joined by the link.
  assumes: both ends run on sys_clk; the data line idles high.
*/
`timescale 1ns/1ps
module tb_usart_sync_slave_port
  import sync_slave_pkg::*;
;
  // =====================================================
  // stimulus and observed signals
  localparam int HALF = 5; // shortened shift clock
  logic        sys_clk     = 1'h0;
  logic        sys_rst     = 1'h1;
  logic        sleep       = 1'h0;
  logic [3:0]  reg_addr    = 4'h0;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_wr      = 1'h0;
  logic        reg_rd      = 1'h0;
  logic        start       = 1'h0;
  logic        drive       = 1'h0;
  logic [3:0]  nbits       = 4'h8;
  logic [8:0]  tx_word     = 9'h000;
  logic [7:0]  reg_rdata;
  logic        irq;
  logic        wake;
  logic        busy;
  logic        done;
  logic [8:0]  rx_word;
  int          failures    = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic [31:0] seed        = 32'h0000_001b;
  sync_link_if link ();
  // line level: driver wins, pull-up otherwise
  assign link.dat_i = link.dat_mst_oe ? link.dat_mst_o :
                      (link.dat_slv_oe ? link.dat_slv_o : 1'h1);
  sync_slave_port u_sync_slave_port (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .sleep(sleep), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .wake(wake));
  sync_clock_master #(.HALF(HALF)) u_sync_clock_master (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link), .start(start), .drive(drive), .nbits(nbits),
    .tx_word(tx_word), .busy(busy), .done(done), .rx_word(rx_word));
  sync_link_chk #(.HALF(HALF)) u_sync_link_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sck(link.sck), .dat_mst_o(link.dat_mst_o), .dat_mst_oe(link.dat_mst_oe),
    .dat_slv_o(link.dat_slv_o), .dat_slv_oe(link.dat_slv_oe), .dat_i(link.dat_i));
  // =====================================================
  // clock and hang guard
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      report_and_stop();
    end
  end
  // =====================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status bits expected after a received word
  function automatic logic [7:0] rx_stat(logic [3:0] nb, logic [8:0] w);
    return (nb == 4'h9) ? {7'h00, w[8]} : 8'h00;
  endfunction
  task automatic check(string n, logic [8:0] seen, logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
    #1;
  endtask
  task automatic rdc(string n, logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    #1 check(n, {1'h0, reg_rdata & m}, {1'h0, e & m});
  endtask
  // one master frame, then an idle gap
  task automatic xfer(logic drv, logic [3:0] nb, logic [8:0] w, output logic [8:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    start   <= 1'h1;
    drive   <= drv;
    nbits   <= nb;
    tx_word <= w;
    @(posedge sys_clk);
    start <= 1'h0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (done !== 1'h1 && n < 400);
    if (n >= 400) begin
      failures++;
      report_and_stop();
    end
    check("busy idle", {8'h00, busy}, 9'h000);
    r = rx_word & ((nb == 4'h9) ? 9'h1ff : 9'h0ff);
    drive <= 1'h0;
    repeat (40) @(posedge sys_clk);
  endtask
  // =====================================================
  // main sequence
  initial begin
    logic [8:0] r;
    logic [8:0] w;
    logic [7:0] v;
    logic [3:0] nb;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rdc("tx_ctrl", ADDR_TX_CTRL, 8'hfd, TX_CTRL_RST);
    rdc("rx_ctrl", ADDR_RX_CTRL, 8'hff, RX_CTRL_RST);
    rdc("irq_mask", ADDR_IRQ_MASK, 8'h03, {6'h00, IRQ_MASK_RST});
    rdc("unmapped", 4'hf, 8'hff, 8'h00);
    // slave transmit: data first, enable later
    wr(ADDR_RX_CTRL, 8'h80);
    wr(ADDR_TX_CTRL, 8'h10);
    wr(ADDR_IRQ_MASK, 8'h01);
    w = {1'h0, 8'(rnd())};
    wr(ADDR_TX_HOLD, w[7:0]);
    xfer(1'h0, 4'h8, 9'h000, r);
    check("tx before enable", r, 9'h0ff);
    wr(ADDR_TX_CTRL, 8'h30);
    v = 8'(rnd());
    wr(ADDR_TX_HOLD, v);
    rdc("hold empty", ADDR_TX_CTRL, 8'h02, 8'h00);
    rdc("tx event", ADDR_IRQ_STAT, 8'h01, 8'h00);
    @(posedge sys_clk);
    sleep <= 1'h1;
    xfer(1'h0, 4'h8, 9'h000, r);
    check("tx word 1", r, w);
    rdc("hold empty", ADDR_TX_CTRL, 8'h02, 8'h02);
    check("irq", {8'h00, irq}, 9'h001);
    check("wake", {8'h00, wake}, 9'h001);
    wr(ADDR_IRQ_STAT, 8'h01);
    check("irq cleared", {8'h00, irq}, 9'h000);
    xfer(1'h0, 4'h8, 9'h000, r);
    check("tx word 2", r, {1'h0, v});
    rdc("tx event", ADDR_IRQ_STAT, 8'h01, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    check("irq masked", {8'h00, irq}, 9'h000);
    wr(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_TX_CTRL, 8'h71);
    w = {1'h1, 8'(rnd())};
    wr(ADDR_TX_HOLD, w[7:0]);
    xfer(1'h0, 4'h9, 9'h000, r);
    check("tx nine", r, w);
    wr(ADDR_TX_CTRL, 8'h10);
    // slave receive
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_RX_CTRL, 8'ha0);
    xfer(1'h1, 4'h8, 9'h0a5, r);
    rdc("single ignored", ADDR_IRQ_STAT, 8'h02, 8'h00);
    wr(ADDR_RX_CTRL, 8'h90);
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 9'h001 : (k == 1) ? 9'h080 : 9'(rnd());
      nb = (k == 5) ? 4'h9 : 4'h8;
      if (k == 5) wr(ADDR_RX_CTRL, 8'hc0);
      if (k == 5) wr(ADDR_RX_CTRL, 8'hd0);
      xfer(1'h1, nb, w, r);
      check("irq rx", {8'h00, irq}, 9'h001);
      check("wake rx", {8'h00, wake}, 9'h001);
      rdc("rx status", ADDR_RX_CTRL, {5'h00, 2'h3, nb == 4'h9}, rx_stat(nb, w));
      rdc("rx data", ADDR_RX_BUF, 8'hff, w[7:0]);
      rdc("frame flag", ADDR_RX_CTRL, 8'h04, 8'h00);
      wr(ADDR_IRQ_STAT, 8'h02);
    end
    wr(ADDR_RX_CTRL, 8'h90);
    xfer(1'h1, 4'h8, 9'h03c, r);
    xfer(1'h1, 4'h8, 9'h0c3, r);
    rdc("overrun", ADDR_RX_CTRL, 8'h02, 8'h02);
    rdc("kept", ADDR_RX_BUF, 8'hff, 8'h3c);
    wr(ADDR_RX_CTRL, 8'h80);
    rdc("overrun off", ADDR_RX_CTRL, 8'h02, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_RX_CTRL, 8'h90);
    // abort in mid-word, re-enable after the frame
    fork
      xfer(1'h1, 4'h8, 9'h0ff, r);
      begin
        repeat (8 * HALF) @(posedge sys_clk);
        wr(ADDR_RX_CTRL, 8'h10);
      end
    join
    wr(ADDR_RX_CTRL, 8'h90);
    rdc("aborted", ADDR_IRQ_STAT, 8'h02, 8'h00);
    xfer(1'h1, 4'h8, 9'h05a, r);
    rdc("after abort", ADDR_RX_BUF, 8'hff, 8'h5a);
    report_and_stop();
  end
endmodule
